// ===== src/fwes_cycle.sv
// Single bus cycle engine that drives the flash strobes for one write or read.
`timescale 1ns/1ns
`default_nettype none
module fwes_cycle
	import fwes_pkg::*;
#(
	parameter int ADDR_W = 20
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_start,
	input wire logic i_is_read,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_data,
	input wire logic [7:0] i_pin_data,
	output logic o_done,
	output logic [7:0] o_rdata,
	output fwes_strobe_type o_strobe,
	output logic [ADDR_W-1:0] o_addr,
	output logic [7:0] o_data,
	output logic o_data_oe
);
	logic [7:0] cnt_q;
	logic busy_q;
	logic gap_q;
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			cnt_q <= 8'h00;
			busy_q <= 1'b0;
			gap_q <= 1'b0;
			o_done <= 1'b0;
			o_rdata <= 8'h00;
			o_strobe <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, write_en_n: 1'b1};
			o_addr <= '0;
			o_data <= 8'h00;
			o_data_oe <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (!busy_q && !gap_q && i_start) begin
				busy_q <= 1'b1;
				cnt_q <= 8'(PULSE_CYCLES);
				o_addr <= i_addr;
				o_data <= i_data;
				o_data_oe <= !i_is_read;
				o_strobe.chip_sel_n <= 1'b0;
				o_strobe.out_en_n <= !i_is_read;
				o_strobe.write_en_n <= i_is_read;
			end else if (busy_q) begin
				if (cnt_q == 8'h00) begin
					// Data is captured on the rising write enable edge, so data stays one more cycle.
					busy_q <= 1'b0;
					gap_q <= 1'b1;
					cnt_q <= 8'(GAP_CYCLES);
					o_rdata <= i_pin_data;
					o_strobe <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, write_en_n: 1'b1};
				end else begin
					cnt_q <= cnt_q - 8'h01;
				end
			end else if (gap_q) begin
				// Strobes stay high between cycles so the device refreshes its status latch.
				o_data_oe <= 1'b0;
				if (cnt_q == 8'h00) begin
					gap_q <= 1'b0;
					o_done <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 8'h01;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== src/fwes_host.sv
// Host controller that sequences write, erase and suspend commands into the flash.
//
// Overview of operation
// - Suspend code may be written during erase.
// - Suspended: only read array, status, resume.
// - Byte write is setup code then data.
// - Erase codes go to address in block.
// - Deselect between successive status reads.
// - Finish series with read array command; the host skips it after suspend, clear and timeouts.
// - Supply bit set blocks writes until clear.
// - Both error bits mean sequence error.
// - Check ready bit before error bits.
// - Erase is setup then confirm in block.
// - Clear command resets error and supply bits.
`timescale 1ns/1ns
`default_nettype none
module fwes_host
	import fwes_pkg::*;
#(
	parameter int ADDR_W = 20,
	parameter int TIMEOUT_CYCLES = ERASE_TIMEOUT_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire fwes_reg_req_type i_req,
	output logic [31:0] o_rdata,
	input wire logic i_ready_busy_out,
	input wire logic [7:0] i_dq,
	output logic [7:0] o_dq,
	output logic o_dq_oe,
	output logic [ADDR_W-1:0] o_addr,
	output fwes_strobe_type o_strobe,
	output logic o_powerdown_n
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CMD1 = 3'b001,
		ST_CMD2 = 3'b011,
		ST_POLL = 3'b010,
		ST_CHECK = 3'b110,
		ST_FINISH = 3'b111
	} fwes_state_type;
	fwes_state_type state_q;
	logic [2:0] op_q;
	logic [ADDR_W-1:0] addr_q;
	logic [7:0] data_q;
	logic [7:0] status_q;
	logic [7:0] result_q;
	logic busy_q;
	logic timeout_q;
	logic blocked_q;
	logic [31:0] wait_q;
	logic phase_q, susp_q;
	logic ry_meta_q, ry_sync_q;
	logic [7:0] dq_meta_q, dq_sync_q;
	logic cyc_start_q, cyc_read_q;
	logic [7:0] cyc_data_q;
	logic cyc_done;
	logic [7:0] cyc_rdata;
	logic cyc_oe;
	logic [7:0] cyc_dq;
	logic [ADDR_W-1:0] cyc_addr;
	fwes_strobe_type cyc_strobe;
	function automatic logic [7:0] first_code(input logic [2:0] op);
		case (op)
			OP_WRITE: first_code = CMD_WRITE_SETUP;
			OP_ERASE: first_code = CMD_ERASE_SETUP;
			OP_SUSPEND: first_code = CMD_SUSPEND;
			OP_RESUME: first_code = CMD_CONFIRM;
			OP_CLEAR: first_code = CMD_CLEAR_STATUS;
			OP_READ_ARRAY: first_code = CMD_READ_ARRAY;
			default: first_code = CMD_READ_STATUS;
		endcase
	endfunction
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			ry_meta_q <= 1'b1;
			ry_sync_q <= 1'b1;
			dq_meta_q <= 8'h00;
			dq_sync_q <= 8'h00;
		end else begin
			ry_meta_q <= i_ready_busy_out;
			ry_sync_q <= ry_meta_q;
			dq_meta_q <= i_dq;
			dq_sync_q <= dq_meta_q;
		end
	end
	fwes_cycle #(.ADDR_W(ADDR_W)) u_cycle (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_start(cyc_start_q),
		.i_is_read(cyc_read_q),
		.i_addr(addr_q),
		.i_data(cyc_data_q),
		.i_pin_data(dq_sync_q),
		.o_done(cyc_done),
		.o_rdata(cyc_rdata),
		.o_strobe(cyc_strobe),
		.o_addr(cyc_addr),
		.o_data(cyc_dq),
		.o_data_oe(cyc_oe)
	);
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_dq <= 8'h00;
			o_dq_oe <= 1'b0;
			o_addr <= '0;
			o_strobe <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, write_en_n: 1'b1};
			o_powerdown_n <= 1'b0;
		end else begin
			o_dq <= cyc_dq;
			o_dq_oe <= cyc_oe;
			o_addr <= cyc_addr;
			o_strobe <= cyc_strobe;
			o_powerdown_n <= 1'b1;
		end
	end
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state_q <= ST_IDLE;
			op_q <= OP_NONE;
			addr_q <= '0;
			data_q <= 8'h00;
			status_q <= 8'h80;
			result_q <= 8'h00;
			busy_q <= 1'b0;
			timeout_q <= 1'b0;
			blocked_q <= 1'b0;
			wait_q <= 32'h0;
			phase_q <= 1'b0;
			susp_q <= 1'b0;
			cyc_start_q <= 1'b0;
			cyc_read_q <= 1'b0;
			cyc_data_q <= 8'h00;
		end else begin
			cyc_start_q <= 1'b0;
			if (i_req.wr && i_req.addr == REG_ADDR) begin
				addr_q <= i_req.wdata[ADDR_W-1:0];
			end
			if (i_req.wr && i_req.addr == REG_DATA) begin
				data_q <= i_req.wdata[7:0];
			end
			case (state_q)
				ST_IDLE: begin
					if (i_req.wr && i_req.addr == REG_CTRL && i_req.wdata[2:0] != OP_NONE) begin
						op_q <= i_req.wdata[2:0];
						busy_q <= 1'b1;
						timeout_q <= 1'b0;
						// A set supply-low bit refuses writes and erases until cleared.
						if (blocked_q && (i_req.wdata[2:0] == OP_WRITE ||
							i_req.wdata[2:0] == OP_ERASE)) begin
							state_q <= ST_FINISH;
						end else begin
							state_q <= ST_CMD1;
						end
					end
				end
				ST_CMD1: begin
					cyc_start_q <= 1'b1;
					cyc_read_q <= (op_q == OP_READ);
					cyc_data_q <= first_code(op_q);
					phase_q <= 1'b0;
					state_q <= ST_CMD2;
				end
				ST_CMD2: begin
					if (cyc_done) begin
						if (op_q == OP_WRITE && !phase_q) begin
							// A phase flag marks the data write, as the data may equal the setup code.
							cyc_start_q <= 1'b1;
							phase_q <= 1'b1;
							cyc_data_q <= data_q;
						end else if (op_q == OP_ERASE && !phase_q) begin
							cyc_start_q <= 1'b1;
							phase_q <= 1'b1;
							cyc_data_q <= CMD_CONFIRM;
						end else if (op_q == OP_READ) begin
							result_q <= cyc_rdata;
							state_q <= ST_FINISH;
						end else if (op_q == OP_READ_ARRAY) begin
							state_q <= ST_FINISH;
						end else begin
							wait_q <= 32'h0;
							state_q <= ST_POLL;
						end
					end
				end
				ST_POLL: begin
					if (i_req.wr && i_req.addr == REG_CTRL && i_req.wdata[2:0] == OP_SUSPEND &&
						op_q == OP_ERASE) begin
						susp_q <= 1'b1;
					end
					// Each poll is its own cycle, so chip select rises between reads.
					if (!cyc_start_q && wait_q[0] == 1'b0) begin
						cyc_start_q <= 1'b1;
						cyc_read_q <= 1'b1;
						wait_q[0] <= 1'b1;
					end
					if (cyc_done) begin
						wait_q <= wait_q + 32'h2;
						wait_q[0] <= 1'b0;
						// Error bits are only meaningful once the ready bit is set.
						if (cyc_rdata[SR_READY] || op_q == OP_CLEAR || op_q == OP_READ_ARRAY) begin
							status_q <= cyc_rdata & SR_USED_MASK;
							state_q <= ST_CHECK;
						end else if (susp_q) begin
							// The suspend code waits for a finished poll so the cycle engine is idle.
							susp_q <= 1'b0;
							op_q <= OP_SUSPEND;
							state_q <= ST_CMD1;
						end else if (wait_q[31:1] >= 31'(TIMEOUT_CYCLES / 64)) begin
							timeout_q <= 1'b1;
							state_q <= ST_FINISH;
						end
					end
				end
				ST_CHECK: begin
					blocked_q <= (op_q == OP_CLEAR) ? 1'b0 : status_q[SR_SUPPLY_LOW];
					if (op_q == OP_SUSPEND && !status_q[SR_SUSPENDED] && !ry_sync_q) begin
						state_q <= ST_POLL;
					end else if (op_q == OP_SUSPEND ||
						op_q == OP_CLEAR || op_q == OP_READ_ARRAY) begin
						state_q <= ST_FINISH;
					end else begin
						op_q <= OP_READ_ARRAY;
						state_q <= ST_CMD1;
					end
				end
				ST_FINISH: begin
					busy_q <= 1'b0;
					susp_q <= 1'b0;
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_rdata <= 32'h0;
		end else if (i_req.rd) begin
			case (i_req.addr)
				REG_ADDR: o_rdata <= 32'(addr_q);
				REG_DATA: o_rdata <= {24'h0, data_q};
				// Both error bits together mark a bad sequence rather than an erase failure.
				REG_STATUS: o_rdata <= {20'h0, blocked_q, timeout_q,
					status_q[SR_ERASE_ERR] & status_q[SR_WRITE_ERR], busy_q, status_q};
				REG_RESULT: o_rdata <= {23'h0, ry_sync_q, result_q};
				default: o_rdata <= 32'h0;
			endcase
		end else begin
			o_rdata <= 32'h0;
		end
	end
	chk_busy_after_start: assert property (@(posedge i_clock) disable iff (i_rst)
		(state_q == ST_IDLE && i_req.wr && i_req.addr == REG_CTRL && i_req.wdata[2:0] != 3'h0)
		|=> busy_q) else $error("Controller did not go busy.");
	chk_strobe_exclusive: assert property (@(posedge i_clock) disable iff (i_rst)
		!(!o_strobe.write_en_n && !o_strobe.out_en_n)) else $error("Write and read strobes overlap.");
	chk_oe_with_write: assert property (@(posedge i_clock) disable iff (i_rst)
		!o_strobe.write_en_n |-> o_dq_oe) else $error("Data not driven during write.");
	chk_deselect_between: assert property (@(posedge i_clock) disable iff (i_rst)
		$rose(o_strobe.chip_sel_n) |=> o_strobe.chip_sel_n [*4]) else $error("Reselected too soon.");
	chk_blocked_refuse: assert property (@(posedge i_clock) disable iff (i_rst)
		(state_q == ST_IDLE && blocked_q && i_req.wr && i_req.addr == REG_CTRL &&
		i_req.wdata[2:0] == OP_WRITE) |=> state_q == ST_FINISH) else $error("Write not refused.");
	chk_clear_unblocks: assert property (@(posedge i_clock) disable iff (i_rst)
		(state_q == ST_CHECK && op_q == OP_CLEAR) |=> !blocked_q) else $error("Clear kept block.");
	chk_status_masked: assert property (@(posedge i_clock) disable iff (i_rst)
		status_q[2:0] == 3'h0) else $error("Reserved status bits kept.");
	chk_finish_idle: assert property (@(posedge i_clock) disable iff (i_rst)
		state_q == ST_FINISH |=> state_q == ST_IDLE && !busy_q) else $error("Finish stuck.");
	sequence seq_erase_held;
		state_q == ST_POLL && op_q == OP_ERASE && susp_q && cyc_done && !cyc_rdata[SR_READY];
	endsequence
	chk_suspend_issue: assert property (@(posedge i_clock) disable iff (i_rst)
		seq_erase_held |=> state_q == ST_CMD1 && op_q == OP_SUSPEND) else $error("Suspend not sent.");
endmodule
`default_nettype wire

// ===== src/fwes_pkg.sv
// Package with command codes, status layout and timing for the flash host controller.
package fwes_pkg;
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
	localparam logic [7:0] CMD_WRITE_SETUP_ALT = 8'h10;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam int SR_READY = 7;
	localparam int SR_SUSPENDED = 6;
	localparam int SR_ERASE_ERR = 5;
	localparam int SR_WRITE_ERR = 4;
	localparam int SR_SUPPLY_LOW = 3;
	localparam logic [7:0] SR_USED_MASK = 8'hF8;
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_ADDR = 3'h1;
	localparam logic [2:0] REG_DATA = 3'h2;
	localparam logic [2:0] REG_STATUS = 3'h3;
	localparam logic [2:0] REG_RESULT = 3'h4;
	localparam logic [2:0] OP_NONE = 3'h0;
	localparam logic [2:0] OP_WRITE = 3'h1;
	localparam logic [2:0] OP_ERASE = 3'h2;
	localparam logic [2:0] OP_SUSPEND = 3'h3;
	localparam logic [2:0] OP_RESUME = 3'h4;
	localparam logic [2:0] OP_CLEAR = 3'h5;
	localparam logic [2:0] OP_READ_ARRAY = 3'h6;
	localparam logic [2:0] OP_READ = 3'h7;
	localparam int CLOCK_MHZ = 125;
	localparam int PULSE_NS = 64;
	localparam int PULSE_CYCLES = (PULSE_NS * CLOCK_MHZ + 999) / 1000;
	localparam int GAP_NS = 32;
	localparam int GAP_CYCLES = (GAP_NS * CLOCK_MHZ + 999) / 1000;
	localparam int ERASE_TYP_MS = 1600;
	localparam int ERASE_TIMEOUT_CYCLES = ERASE_TYP_MS * CLOCK_MHZ * 1000 * 2;
	typedef struct packed {
		logic chip_sel_n;
		logic out_en_n;
		logic write_en_n;
	} fwes_strobe_type;
	typedef struct packed {
		logic [2:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} fwes_reg_req_type;
endpackage

// ===== tb/fwes_flash_model.sv
// Behavioural flash device that answers the host's command writes and reads.
`timescale 1ns/1ns
`default_nettype none
module fwes_flash_model
	import fwes_pkg::*;
#(
	parameter int WRITE_TICKS = 40,
	parameter int ERASE_TICKS = 200
) (
	input wire fwes_strobe_type i_strobe,
	input wire logic [19:0] i_addr,
	input wire logic [7:0] i_dq,
	input wire logic i_powerdown_n,
	input wire logic i_supply_low,
	input wire logic i_verify_fail,
	output logic o_ready_busy_out,
	output logic [7:0] o_dq
);
	logic [7:0] mem [16];
	logic [7:0] status_q = 8'h80;
	logic [7:0] latch_q = 8'h00;
	logic show_q = 1'b0;
	logic [1:0] pend_q = 2'h0;
	logic erasing_q = 1'b0;
	int busy_q = 0;
	logic [3:0] wa_q;
	logic [7:0] wd_q;
	logic wr_low;
	initial for (int i = 0; i < 16; i++) mem[i] = 8'hFF;
	assign o_ready_busy_out = !i_powerdown_n || status_q[7];
	assign wr_low = !i_strobe.chip_sel_n && !i_strobe.write_en_n;
	// Suspension stops the countdown because the ready bit is set meanwhile.
	always #7 if (!status_q[7] && busy_q > 0) begin
		busy_q--;
		if (busy_q == 0) begin
			if (erasing_q) for (int i = 0; i < 16; i++) mem[i] = 8'hFF;
			else mem[wa_q] = mem[wa_q] & wd_q;
			if (!erasing_q && i_verify_fail) status_q[4] = 1'b1;
			status_q[7] = 1'b1;
		end
	end
	always @(posedge i_supply_low) if (!status_q[7]) begin
		busy_q = 0;
		status_q[7] = 1'b1;
		status_q[3] = 1'b1;
	end
	always @(negedge i_powerdown_n) begin
		busy_q = 0;
		status_q = 8'h80;
		show_q = 1'b0;
		pend_q = 2'h0;
	end
	// A command is taken when chip select or write enable rises, whichever comes first.
	always @(negedge wr_low) if (i_powerdown_n) begin
		if (pend_q != 2'h0) begin
			show_q = 1'b1;
			if (pend_q == 2'h2 && i_dq != CMD_CONFIRM) status_q[5:4] = 2'h3;
			else if (i_supply_low) status_q[3] = 1'b1;
			else if (!status_q[3]) begin
				erasing_q = pend_q[1];
				busy_q = pend_q[1] ? ERASE_TICKS : WRITE_TICKS;
				wa_q = i_addr[3:0];
				wd_q = i_dq;
				status_q[7] = 1'b0;
			end
			pend_q = 2'h0;
		end else if (status_q[6]) begin
			if (i_dq == CMD_CONFIRM) status_q[7:6] = 2'h0;
			if (i_dq inside {CMD_READ_ARRAY, CMD_READ_STATUS, CMD_CONFIRM}) begin
				show_q = i_dq != CMD_READ_ARRAY;
			end
		end else if (!status_q[7]) begin
			if (erasing_q && i_dq == CMD_SUSPEND) status_q[7:6] = 2'h3;
			show_q = 1'b1;
		end else begin
			show_q = i_dq != CMD_READ_ARRAY;
			if (i_dq == CMD_CLEAR_STATUS) status_q[5:3] = 3'h0;
			if (i_dq inside {CMD_WRITE_SETUP, CMD_WRITE_SETUP_ALT}) pend_q = 2'h1;
			if (i_dq == CMD_ERASE_SETUP) pend_q = 2'h2;
		end
	end
	// The short delay lets the host's address settle after the strobe edge.
	always @(negedge i_strobe.out_en_n or negedge i_strobe.chip_sel_n) begin
		#1 if (!i_strobe.out_en_n && !i_strobe.chip_sel_n) begin
			latch_q = show_q ? (status_q & SR_USED_MASK) : mem[i_addr[3:0]];
		end
	end
	assign o_dq = (!i_strobe.out_en_n && !i_strobe.chip_sel_n) ? latch_q : ~latch_q;
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the flash host controller against the device model.
`timescale 1ns/1ns
`default_nettype none
module tb;
	import fwes_pkg::*;
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	fwes_reg_req_type req = '0;
	logic [31:0] rdata;
	logic rb, oe, powerdown_n;
	logic sup_low = 1'b0;
	logic vfail = 1'b0;
	logic [7:0] h_dq, d_dq, dq_bus;
	logic [19:0] addr;
	fwes_strobe_type strobe;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [31:0] v;
	assign dq_bus = oe ? h_dq : d_dq;
	fwes_host #(.TIMEOUT_CYCLES(6400)) u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_req(req),
		.o_rdata(rdata), .i_ready_busy_out(rb), .i_dq(dq_bus), .o_dq(h_dq), .o_dq_oe(oe),
		.o_addr(addr), .o_strobe(strobe), .o_powerdown_n(powerdown_n));
	fwes_flash_model u_dev (.i_strobe(strobe), .i_addr(addr), .i_dq(dq_bus),
		.i_powerdown_n(powerdown_n), .i_supply_low(sup_low), .i_verify_fail(vfail),
		.o_ready_busy_out(rb), .o_dq(d_dq));
	initial forever #4 i_clock = ~i_clock;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		@(posedge i_clock);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clock);
		req <= '0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [31:0] d);
		@(posedge i_clock);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge i_clock);
		req <= '0;
		#1 d = rdata;
	endtask
	// A hang here is cut short by the cycle ceiling below.
	task automatic poll();
		rd(REG_STATUS, v);
		while (v[8] !== 1'b0) rd(REG_STATUS, v);
	endtask
	task automatic go(input logic [2:0] code);
		wr(REG_CTRL, {29'h0, code});
		poll();
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			mismatches++;
			report_and_stop();
		end
	end
	initial begin
		repeat (4) @(posedge i_clock);
		chk({strobe, powerdown_n}, 4'hE, "reset pins");
		i_rst <= 1'b0;
		wr(REG_ADDR, 32'h3);
		wr(REG_DATA, 32'h5A);
		go(OP_WRITE);
		chk(v[11:0], 12'h080, "write");
		go(OP_READ);
		rd(REG_RESULT, v);
		chk(v[8:0], 9'h15A, "read");
		vfail <= 1'b1;
		go(OP_WRITE);
		chk(v[7:0], 8'h90, "fail");
		vfail <= 1'b0;
		go(OP_WRITE);
		chk(v[7:0], 8'h90, "keep");
		go(OP_ERASE);
		chk(v[7:0], 8'h90, "erase");
		go(OP_READ);
		rd(REG_RESULT, v);
		chk(v[7:0], 8'hFF, "erased");
		go(OP_CLEAR);
		go(OP_WRITE);
		chk(v[7:0], 8'h80, "cleared");
		sup_low <= 1'b1;
		go(OP_WRITE);
		chk(v[7:0], 8'h88, "low");
		go(OP_WRITE);
		chk(v[11], 1'b1, "blocked");
		sup_low <= 1'b0;
		go(OP_CLEAR);
		wr(REG_CTRL, {29'h0, OP_ERASE});
		repeat (60) @(posedge i_clock);
		sup_low <= 1'b1;
		poll();
		chk(v[7:0], 8'h88, "abort");
		sup_low <= 1'b0;
		go(OP_CLEAR);
		go(OP_SUSPEND);
		chk(v[8:7], 2'h1, "suspend");
		wr(REG_CTRL, {29'h0, OP_ERASE});
		repeat (60) @(posedge i_clock);
		go(OP_SUSPEND);
		chk(v[8:0], 9'h0C0, "suspended");
		rd(REG_RESULT, v);
		chk(v[8], 1'b1, "ready pin");
		go(OP_READ_ARRAY);
		go(OP_READ);
		rd(REG_RESULT, v);
		chk(v[7:0], 8'h5A, "suspend read");
		go(OP_RESUME);
		chk(v[8:0], 9'h080, "resumed");
		go(OP_READ);
		rd(REG_RESULT, v);
		chk(v[7:0], 8'hFF, "resume done");
		rd(3'h5, v);
		chk(v, 32'h0, "unmapped");
		report_and_stop();
	end
endmodule
`default_nettype wire
